// file: inc/pwd_defines.svh
// Register offsets, field positions, reset values for the pin wake detector
`ifndef PWD_DEFINES_SVH
`define PWD_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PWD_OFS_STATUS_CONTROL 4'h0
`define PWD_OFS_PIN_ENABLE 4'h4
`define PWD_OFS_POLARITY 4'h8
`define PWD_OFS_PIN_LEVEL 4'hC

// ****************************************************************
// Status/control field positions
// ****************************************************************
`define PWD_BIT_MODE 0
`define PWD_BIT_IRQ_ENABLE 1
`define PWD_BIT_ACK 2
`define PWD_BIT_FLAG 3

// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define PWD_RST_PINS 4'h0
`define PWD_RST_BIT 1'b0
`define PWD_PIN_COUNT 4
`define PWD_SYNC_STAGES 2
`define PWD_RESP_OKAY 2'h0
`define PWD_RESP_SLVERR 2'h2

`endif

// file: inc/pwd_pkg.sv
// Types shared by the pin wake detector modules
`default_nettype none
package pwd_pkg;
    // Detection mode of the status/control register
    typedef enum logic {
        PWD_EDGE_ONLY = 1'b0,
        PWD_EDGE_LEVEL = 1'b1
    } pwd_mode_type;
    // Bus response code
    typedef logic [1:0] pwd_resp_type;
endpackage
`default_nettype wire

// file: inc/pwd_det_if.sv
// Carrier between the controller and the pin detector
`default_nettype none
interface pwd_det_if #(parameter int N = 4);
    logic [N-1:0] pin_level;
    logic [N-1:0] enable;
    logic [N-1:0] polarity;
    logic [N-1:0] asserted;
    logic [N-1:0] edge_hit;
    modport ctrl (output pin_level, output enable, output polarity,
        input asserted, input edge_hit);
    modport det (input pin_level, input enable, input polarity,
        output asserted, output edge_hit);
endinterface
`default_nettype wire

// file: verilog/pwd_sync.sv
// Two-stage synchroniser for the wake input pins
`default_nettype none
`include "pwd_defines.svh"
module pwd_sync #(
    parameter int W = `PWD_PIN_COUNT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// file: verilog/pwd_detect.sv
// Per-pin edge and level detection for the pin wake detector
`default_nettype none
module pwd_detect #(
    parameter int N = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    pwd_det_if.det det
);
    logic [N-1:0] prev_active_q;
    logic [N-1:0] armed_q;
    wire [N-1:0] active;

    // Asserted level per polarity: 0 low, 1 high
    assign active = ~(det.pin_level ^ det.polarity);
    assign det.asserted = det.enable & active;
    // Inactive one cycle then active the next
    assign det.edge_hit = det.enable & armed_q & ~prev_active_q
        & active;

    // Arm only after the inactive level was seen while enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_active_q <= '0;
            armed_q <= '0;
        end else if (clear) begin
            prev_active_q <= '0;
            armed_q <= '0;
        end else begin
            prev_active_q <= active;
            armed_q <= det.enable & (armed_q | ~active);
        end
    end
endmodule
`default_nettype wire

// file: verilog/pwd_top.sv
// Pin wake detector: AXI4-Lite registers, flag, interrupt, pull control
// How it works
// - falling edge is high one cycle then low the next.
// - rising edge is low one cycle then high the next.
// - edge counts only after the input was seen inactive.
// - mode bit 0 picks edge only or edge plus level.
// - polarity bit 0 means falling/low, 1 means rising/high.
// - disabled inputs never contribute to detection.
// - edge only mode sets the flag on any valid edge.
// - edge plus level mode sets flag on edge or asserted level.
// - software writes to the flag bit are ignored.
// - interrupt request while flag and irq enable bit are set.
// - writing one to acknowledge clears flag; it reads as zero.
// - in level mode acknowledge clears only if no input asserted.
// - status/control bits 7 to 4 read as zero.
// - shallow stop keeps detecting and wakes when irq enabled.
// - deep stop disables the block and returns it to reset.
// - debug mode does not halt or freeze the block.
// - enabled resistor is pull-up at polarity 0, pull-down at 1.
// - port A pins 3..0 map to enable/polarity bits 3..0.
// - pull enable turns resistor on, never on output pins.
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
`include "pwd_defines.svh"
module pwd_top #(
    parameter int N = `PWD_PIN_COUNT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output pwd_pkg::pwd_resp_type s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output pwd_pkg::pwd_resp_type s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [N-1:0] wake_input_pin,
    input wire logic [N-1:0] port_a_pull_enable,
    input wire logic [N-1:0] port_a_dir_output,
    input wire logic shallow_stop_mode,
    input wire logic deep_stop_mode,
    output logic detect_irq,
    output logic wake_request,
    output logic [N-1:0] pull_up_on,
    output logic [N-1:0] pull_down_on
);
    import pwd_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [3:0] aw_addr_q;
    logic aw_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_held_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    pwd_resp_type bresp_q;
    logic arready_q;
    logic rvalid_q;
    pwd_resp_type rresp_q;
    logic [31:0] rdata_q;
    pwd_mode_type mode_q;
    logic irq_en_q;
    logic flag_q;
    logic flag_d;
    logic [N-1:0] enable_q;
    logic [N-1:0] polarity_q;
    logic irq_q;
    logic wake_q;
    logic [N-1:0] pull_up_q;
    logic [N-1:0] pull_down_q;
    logic [N-1:0] pins_sync;

    pwd_det_if #(.N(N)) det_bus ();

    // ****************************************************************
    // Pin input path
    // ****************************************************************

    // Pins come from outside the clock domain
    pwd_sync #(.W(N)) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in(wake_input_pin),
        .sync_out(pins_sync)
    );

    // Pin n drives enable and polarity bit n
    assign det_bus.pin_level = pins_sync;
    assign det_bus.enable = enable_q;
    assign det_bus.polarity = polarity_q;

    // Deep stop holds the detector cleared
    pwd_detect #(.N(N)) u_detect (
        .clk(clk),
        .rst(rst),
        .clear(deep_stop_mode),
        .det(det_bus)
    );

    // ****************************************************************
    // Write channel decode
    // ****************************************************************

    // Address and data may arrive in either order
    wire aw_take = s_axi_awvalid && awready_q;
    wire w_take = s_axi_wvalid && wready_q;
    wire aw_have = aw_held_q || aw_take;
    wire w_have = w_held_q || w_take;
    wire [3:0] wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
    wire [3:0] wr_strb = w_held_q ? w_strb_q : s_axi_wstrb;
    wire wr_fire = aw_have && w_have && !bvalid_q;
    wire wr_lane0 = wr_fire && wr_strb[0];

    // Register selects for the write
    wire wr_sc_sel = (wr_addr == `PWD_OFS_STATUS_CONTROL);
    wire wr_pe_sel = (wr_addr == `PWD_OFS_PIN_ENABLE);
    wire wr_pol_sel = (wr_addr == `PWD_OFS_POLARITY);
    wire wr_lvl_sel = (wr_addr == `PWD_OFS_PIN_LEVEL);
    wire wr_mapped = wr_sc_sel || wr_pe_sel || wr_pol_sel || wr_lvl_sel;
    wire wr_sc = wr_lane0 && wr_sc_sel;
    wire wr_pe = wr_lane0 && wr_pe_sel;
    wire wr_pol = wr_lane0 && wr_pol_sel;

    // Acknowledge is a write strobe, never stored
    wire ack_req = wr_sc && wr_data[`PWD_BIT_ACK];

    // ****************************************************************
    // Write channel handshake
    // ****************************************************************

    // Address capture when it arrives before the data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 4'h0;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end else if (aw_take) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
    end

    // Data capture when it arrives before the address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end else if (w_take) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
    end

    // Ready drops once a beat is held or a response waits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
        end else begin
            awready_q <= !bvalid_q && !wr_fire && !aw_have;
            wready_q <= !bvalid_q && !wr_fire && !w_have;
        end
    end

    // Write response, unmapped address answers SLVERR
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= `PWD_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? `PWD_RESP_OKAY : `PWD_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************

    // Mode and irq enable; flag and ack bits are not stored here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q <= PWD_EDGE_ONLY;
            irq_en_q <= `PWD_RST_BIT;
        end else if (deep_stop_mode) begin
            mode_q <= PWD_EDGE_ONLY;
            irq_en_q <= `PWD_RST_BIT;
        end else if (wr_sc) begin
            mode_q <= pwd_mode_type'(wr_data[`PWD_BIT_MODE]);
            irq_en_q <= wr_data[`PWD_BIT_IRQ_ENABLE];
        end
    end

    // Pin enable register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_q <= `PWD_RST_PINS;
        end else if (deep_stop_mode) begin
            enable_q <= `PWD_RST_PINS;
        end else if (wr_pe) begin
            enable_q <= wr_data[N-1:0];
        end
    end

    // Polarity register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            polarity_q <= `PWD_RST_PINS;
        end else if (deep_stop_mode) begin
            polarity_q <= `PWD_RST_PINS;
        end else if (wr_pol) begin
            polarity_q <= wr_data[N-1:0];
        end
    end

    // ****************************************************************
    // Detection flag
    // ****************************************************************

    // Level term only counts in edge plus level mode
    wire any_edge = |det_bus.edge_hit;
    wire any_level = |det_bus.asserted;
    wire level_mode = (mode_q == PWD_EDGE_LEVEL);
    wire flag_set = any_edge || (level_mode && any_level);
    // In edge plus level mode an asserted enabled input blocks the acknowledge
    wire ack_ok = !level_mode || !any_level;
    wire flag_clr = ack_req && ack_ok;

    // Set wins over clear; bus writes of the flag bit do nothing
    always_comb begin
        flag_d = flag_q;
        if (flag_clr) begin
            flag_d = 1'b0;
        end
        if (flag_set) begin
            flag_d = 1'b1;
        end
    end

    // Flag storage; it runs on regardless of debug mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= `PWD_RST_BIT;
        end else if (deep_stop_mode) begin
            flag_q <= `PWD_RST_BIT;
        end else begin
            flag_q <= flag_d;
        end
    end

    // ****************************************************************
    // Interrupt and wake outputs
    // ****************************************************************

    // Request follows the flag gated by irq enable
    wire irq_d = flag_d && irq_en_q && !deep_stop_mode;
    // Shallow stop turns a request into a wake
    wire wake_d = irq_d && shallow_stop_mode;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
            wake_q <= wake_d;
        end
    end

    // ****************************************************************
    // Pull resistor control
    // ****************************************************************

    // Resistor on only for an input pin with pull enabled
    wire [N-1:0] pull_on = port_a_pull_enable & ~port_a_dir_output;
    // Polarity picks up or down
    wire [N-1:0] up_d = pull_on & ~polarity_q;
    wire [N-1:0] down_d = pull_on & polarity_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pull_up_q <= '0;
            pull_down_q <= '0;
        end else begin
            pull_up_q <= up_d;
            pull_down_q <= down_d;
        end
    end

    // ****************************************************************
    // Read channel
    // ****************************************************************

    // Status/control read: ack and bits 7..4 read zero
    wire [31:0] rd_sc = {24'h0, 4'h0, flag_q, 1'b0, irq_en_q,
        mode_q};
    wire [31:0] rd_pe = {{(32 - N){1'b0}}, enable_q};
    wire [31:0] rd_pol = {{(32 - N){1'b0}}, polarity_q};
    wire [31:0] rd_lvl = {{(32 - N){1'b0}}, pins_sync};

    // Read selects
    wire rd_sc_sel = (s_axi_araddr == `PWD_OFS_STATUS_CONTROL);
    wire rd_pe_sel = (s_axi_araddr == `PWD_OFS_PIN_ENABLE);
    wire rd_pol_sel = (s_axi_araddr == `PWD_OFS_POLARITY);
    wire rd_lvl_sel = (s_axi_araddr == `PWD_OFS_PIN_LEVEL);
    wire rd_mapped = rd_sc_sel || rd_pe_sel || rd_pol_sel || rd_lvl_sel;
    wire [31:0] rd_mux = rd_sc_sel ? rd_sc :
        rd_pe_sel ? rd_pe :
        rd_pol_sel ? rd_pol :
        rd_lvl_sel ? rd_lvl : 32'h0;
    wire ar_take = s_axi_arvalid && arready_q;

    // Address ready only while no read data waits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b0;
        end else begin
            arready_q <= !rvalid_q && !ar_take;
        end
    end

    // Read data one cycle after the address is taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= `PWD_RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_mapped ? `PWD_RESP_OKAY : `PWD_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Output drive
    // ****************************************************************
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign detect_irq = irq_q;
    assign wake_request = wake_q;
    assign pull_up_on = pull_up_q;
    assign pull_down_on = pull_down_q;
endmodule
`default_nettype wire

// file: tb/pwd_top_props.sv
// Port checker for the pin wake detector
`default_nettype none
module pwd_top_props #(parameter int N = 4) (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [N-1:0] port_a_pull_enable,
    input wire logic [N-1:0] port_a_dir_output,
    input wire logic shallow_stop_mode,
    input wire logic deep_stop_mode,
    input wire logic detect_irq,
    input wire logic wake_request,
    input wire logic [N-1:0] pull_up_on,
    input wire logic [N-1:0] pull_down_on
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ****************
    // Bus handshakes
    // ****************
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
    property p_r_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_ans: assert property (p_r_ans) else $error("read answer late");
    // ****************
    // Pins, stop modes and request
    // ****************
    property p_pull_dir;
        !(|((pull_up_on | pull_down_on) & $past(port_a_dir_output)));
    endproperty
    a_pull_dir: assert property (p_pull_dir) else $error("pull on output");
    property p_pull_en;
        !(|((pull_up_on | pull_down_on) & ~$past(port_a_pull_enable)));
    endproperty
    a_pull_en: assert property (p_pull_en) else $error("pull not asked");
    property p_pull_one;
        !(|(pull_up_on & pull_down_on));
    endproperty
    a_pull_one: assert property (p_pull_one) else $error("both pulls on");
    property p_wake;
        wake_request == (detect_irq && $past(shallow_stop_mode));
    endproperty
    a_wake: assert property (p_wake) else $error("wake mismatch");
    property p_deep;
        deep_stop_mode [*2] |=> !detect_irq && !wake_request;
    endproperty
    a_deep: assert property (p_deep) else $error("request in deep stop");
    property p_rst;
        $past(rst) |-> !detect_irq && !wake_request;
    endproperty
    a_rst: assert property (p_rst) else $error("request after reset");
endmodule
bind pwd_top pwd_top_props #(.N(N)) chk_u (.clk(clk), .rst(rst),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .port_a_pull_enable(port_a_pull_enable),
    .port_a_dir_output(port_a_dir_output),
    .shallow_stop_mode(shallow_stop_mode), .deep_stop_mode(deep_stop_mode),
    .detect_irq(detect_irq), .wake_request(wake_request),
    .pull_up_on(pull_up_on), .pull_down_on(pull_down_on));
`default_nettype wire

// file: tb/pwd_switch_model.sv
// Switches and resistors on the four wake input pins
`default_nettype none
module pwd_switch_model (
    input wire logic clk,
    input wire logic [3:0] closed,
    input wire logic [3:0] closed_level,
    input wire logic [3:0] pull_up_on,
    input wire logic [3:0] pull_down_on,
    output logic [3:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin = 4'hF;
    // Open pins follow their resistor, unpulled ones float and wander
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (closed[i])
                pin[i] <= closed_level[i];
            else if (pull_up_on[i])
                pin[i] <= 1'h1;
            else if (pull_down_on[i])
                pin[i] <= 1'h0;
            else
                pin[i] <= ~pin[i];
        end
    end
endmodule
`default_nettype wire

// file: tb/pwd_top_tb.sv
// Self-checking bench for the pin wake detector
`default_nettype none
`include "pwd_defines.svh"
module pwd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pwd_pkg::*;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [3:0] awa = 4'h0;
    logic [3:0] ara = 4'h0;
    logic [31:0] wd = 32'h0;
    logic awv = 1'h0;
    logic wv = 1'h0;
    logic br = 1'h0;
    logic arv = 1'h0;
    logic rr = 1'h0;
    logic [3:0] pe = 4'h0;
    logic [3:0] dir = 4'h0;
    logic [3:0] cls = 4'h0;
    logic [3:0] lvl = 4'h0;
    logic shal = 1'h0;
    logic deep = 1'h0;
    logic awr, wrd, bv, arr, rv, irq, wake;
    logic [31:0] rdd;
    pwd_resp_type bs, rs;
    logic [3:0] pin, pu, pd;
    int fails = 0;
    int samples_checked = 0;
    // Clock of 25 ns
    always #12.5 clk = ~clk;
    // Device and pin partner
    pwd_top dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bs), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdd), .s_axi_rresp(rs), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .wake_input_pin(pin),
        .port_a_pull_enable(pe), .port_a_dir_output(dir),
        .shallow_stop_mode(shal), .deep_stop_mode(deep),
        .detect_irq(irq), .wake_request(wake), .pull_up_on(pu),
        .pull_down_on(pd));
    pwd_switch_model sw_u (.clk(clk), .closed(cls), .closed_level(lvl),
        .pull_up_on(pu), .pull_down_on(pd), .pin(pin));
    // ****************
    // Bus and compare tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic stall(input int n);
        if (n >= 50) begin
            fails++;
            $display("BAD handshake expected answer seen none");
            give_verdict();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic ta, tw, da, dw;
        int n;
        da = 1'h0;
        dw = 1'h0;
        @(posedge clk);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        for (n = 0; n < 50 && !(da && dw); n++) begin
            @(negedge clk);
            ta = !da && awr === 1'h1;
            tw = !dw && wrd === 1'h1;
            @(posedge clk);
            if (ta)
                awv <= 1'h0;
            if (tw)
                wv <= 1'h0;
            da |= ta;
            dw |= tw;
        end
        stall(n);
        da = 1'h0;
        for (n = 0; n < 50 && !da; n++) begin
            @(negedge clk);
            da = bv === 1'h1;
            if (da)
                chk("bresp", 32'(`PWD_RESP_OKAY), 32'(bs));
            @(posedge clk);
        end
        br <= 1'h0;
        stall(n);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        logic ok;
        int n;
        ok = 1'h0;
        @(posedge clk);
        ara <= a;
        arv <= 1'h1;
        rr <= 1'h1;
        for (n = 0; n < 50 && !ok; n++) begin
            @(negedge clk);
            ok = arr === 1'h1;
            @(posedge clk);
        end
        arv <= 1'h0;
        stall(n);
        ok = 1'h0;
        for (n = 0; n < 50 && !ok; n++) begin
            @(negedge clk);
            ok = rv === 1'h1;
            d = rdd;
            if (ok)
                chk("rresp", 32'(a[1:0] == 2'h0 ? `PWD_RESP_OKAY :
                    `PWD_RESP_SLVERR), 32'(rs));
            @(posedge clk);
        end
        rr <= 1'h0;
        stall(n);
    endtask
    // Status byte and request line against expectation
    task automatic sc(input logic [7:0] e);
        logic [31:0] d;
        rd(`PWD_OFS_STATUS_CONTROL, d);
        chk("status", {24'h0, e}, d);
        chk("irq", 32'(e[3] & e[1]), 32'(irq));
    endtask
    task automatic pins(input logic [3:0] c, input logic [3:0] l);
        @(posedge clk);
        cls <= c;
        lvl <= l;
        repeat (8) @(posedge clk);
    endtask
    // Mask, polarity, pulls, enables, acknowledge, unmask
    task automatic init(input logic m, input logic [3:0] p,
        input logic [3:0] en);
        wr(`PWD_OFS_STATUS_CONTROL, 8'h00);
        wr(`PWD_OFS_POLARITY, {4'h0, p});
        pe <= 4'hF;
        wr(`PWD_OFS_PIN_ENABLE, {4'h0, en});
        repeat (8) @(posedge clk);
        wr(`PWD_OFS_STATUS_CONTROL, {7'h02, m});
        wr(`PWD_OFS_STATUS_CONTROL, {7'h01, m});
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        logic [31:0] d;
        for (int i = 0; i < 4; i++) begin
            rd(4'(4 * i), d);
            if (i < 3)
                chk("reset value", 32'h0, d);
        end
        // Unaligned address is unmapped: error response, data zero
        rd(4'h2, d);
        chk("unmapped", 32'h0, d);
    endtask
    task automatic t_fall();
        init(1'h0, 4'h0, 4'h4);
        chk("pull up", 32'hF, 32'(pu));
        sc(8'h02);
        pins(4'h4, 4'h0);
        sc(8'h0A);
        wr(`PWD_OFS_STATUS_CONTROL, 8'h0E);
        sc(8'h02);
        wr(`PWD_OFS_STATUS_CONTROL, 8'hFA);
        sc(8'h02);
        pins(4'h8, 4'h0);
        sc(8'h02);
        wr(`PWD_OFS_STATUS_CONTROL, 8'h00);
        pins(4'h4, 4'h0);
        sc(8'h08);
    endtask
    task automatic t_rise();
        init(1'h0, 4'hF, 4'h1);
        chk("pull down", 32'hF, 32'(pd));
        pins(4'h1, 4'h1);
        sc(8'h0A);
    endtask
    task automatic t_level();
        init(1'h1, 4'h0, 4'h1);
        pins(4'h1, 4'h0);
        sc(8'h0B);
        wr(`PWD_OFS_STATUS_CONTROL, 8'h07);
        sc(8'h0B);
        pins(4'h0, 4'h0);
        wr(`PWD_OFS_STATUS_CONTROL, 8'h07);
        sc(8'h03);
        wr(`PWD_OFS_STATUS_CONTROL, 8'h02);
        wr(`PWD_OFS_PIN_ENABLE, 8'h00);
        pins(4'h2, 4'h0);
        wr(`PWD_OFS_PIN_ENABLE, 8'h02);
        repeat (8) @(posedge clk);
        sc(8'h02);
        pins(4'h0, 4'h0);
        pins(4'h2, 4'h0);
        sc(8'h0A);
    endtask
    task automatic t_stop();
        shal <= 1'h1;
        wr(`PWD_OFS_STATUS_CONTROL, 8'h06);
        pins(4'h0, 4'h0);
        chk("wake", 32'h0, 32'(wake));
        pins(4'h2, 4'h0);
        chk("wake", 32'h1, 32'(wake));
        dir <= 4'h1;
        deep <= 1'h1;
        repeat (3) @(posedge clk);
        deep <= 1'h0;
        chk("pull up", 32'hE, 32'(pu));
        sc(8'h00);
        t_reset();
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_fall();
        t_rise();
        t_level();
        t_stop();
        give_verdict();
    end
endmodule
`default_nettype wire
